// >>> svr_pkg.sv
/*
  shared constants and types of the serial voltage reference control block.
  assumes a 100 MHz SYS_CLK; no other file defines these names.
*/
// Contract
// - boot pins pick 1.1/1.0/0.9/0.8 V start code
// - enable rise latches decoded start code
// - soft-start ramps references near 2 mV/us
// - power good only after ramp completes
// - enable loss or reset: drivers off, output_power_good low
// - restart re-reads pins, soft-starts again
// - fixed mode straps pick 1.4/1.2/1.0/0.8 V
// - command steps addressed planes to new code
// - code step 12.5 mV below 1.55; 7C off
// - core plane off keeps output_power_good high
// - power ok loss returns planes to held code
// - power ok return waits for new command
// - enable loss clears held code
// - reset discards held code, stops regulators
// - command slew about 7.5, at most 10 mV/us
// - downward steps force continuous conduction
// - voltage changes leave output_power_good untouched
// - valid command bytes are acknowledged
// - processor is link master, block is slave
// - two-wire signalling like high-speed i2c
// - send-byte frame, apply after stop
// - address 110, bits 2..0 pick planes
// - data bit 7 hint, bits 6..0 code
package svr_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int SYS_CLK_MHZ   = 100;
  localparam int SOFT_STEP_NS  = 6250;
  localparam int SLEW_STEP_NS  = 1667;
  localparam int SOFT_STEP_CYC = (SOFT_STEP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SLEW_STEP_CYC = (SLEW_STEP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DIV_W         = 10;

  // ****************************************************
  // voltage codes
  // ****************************************************
  localparam int              CODE_W   = 7;
  localparam logic [6:0]      CODE_OFF = 7'h7C;
  localparam logic [3:0][6:0] BOOT_CODE = {7'h3C, 7'h34, 7'h2C, 7'h24};
  localparam logic [3:0][6:0] FIX_CODE  = {7'h3C, 7'h2C, 7'h1C, 7'h0C};

  // ****************************************************
  // link frame fields
  // ****************************************************
  localparam logic [2:0] ADDR_HI   = 3'h6;
  localparam int         BYTE_BITS = 8;

  // ****************************************************
  // register map, byte addresses
  // ****************************************************
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_TARGET = 5'h08;
  localparam logic [4:0] OFS_REF    = 5'h0C;
  localparam int         CTRL_LINK  = 0;
  localparam int         CTRL_CCM   = 1;
  localparam logic [1:0] CTRL_RST   = 2'h1;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_SOFT = 2'b01,
    ST_BOOT = 2'b10,
    ST_SVI  = 2'b11
  } svr_state_t;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_ADDR = 3'b001,
    LK_AACK = 3'b010,
    LK_DATA = 3'b011,
    LK_DACK = 3'b100,
    LK_WAIT = 3'b101
  } svr_link_t;

endpackage

// >>> svr_ramp.sv
/*
  one plane reference stepper: moves its code one step per tick.
  assumes tick is a one-cycle pulse on SYS_CLK from the parent divider.
*/
`timescale 1ns/10ps
module svr_ramp (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   zero,
  input  wire logic                   tick,
  input  wire logic [svr_pkg::CODE_W-1:0] target,
  output logic      [svr_pkg::CODE_W-1:0] ref_code,
  output logic                        down
);
  import svr_pkg::*;

  typedef struct packed {
    logic [CODE_W-1:0] ref_c;
  } svr_ramp_t;

  svr_ramp_t r_q;
  svr_ramp_t r_d;
  logic [CODE_W-1:0] goal;

  // ****************************************************
  // stepping
  // ****************************************************
  always_comb begin
    r_d  = r_q;
    goal = (target >= CODE_OFF) ? CODE_OFF : target;
    if (zero) begin
      r_d.ref_c = CODE_OFF;
    end else if (tick && r_q.ref_c < goal) begin
      r_d.ref_c = r_q.ref_c + 7'h01;
    end else if (tick && r_q.ref_c > goal) begin
      r_d.ref_c = r_q.ref_c - 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_q.ref_c <= CODE_OFF;
    end else begin
      r_q <= r_d;
    end
  end

  assign ref_code = r_q.ref_c;
  assign down     = r_q.ref_c < goal;

  // ****************************************************
  // checks
  // ****************************************************
  chk_step_tick: assert property (@(posedge clk) disable iff (rst)
    !$past(zero) && $changed(r_q.ref_c) |-> $past(tick)
    && (r_q.ref_c - $past(r_q.ref_c) == 7'h01
    || $past(r_q.ref_c) - r_q.ref_c == 7'h01))
    else $error("reference moved without a single tick step");

endmodule // svr_ramp

// >>> svr_ctrl.sv
/*
  serial voltage reference control: start-up code, soft-start, power good,
  serial link slave, on-the-fly slewing and an Avalon-MM register slave.
  assumes link pins and power inputs are asynchronous to SYS_CLK; the link
  data wire is open drain and resolved outside.
*/
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module svr_ctrl (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RESET,
  input  wire logic                       ENABLE,
  input  wire logic                       BIAS_POR,
  input  wire logic                       PROCESSOR_POWER_OK,
  input  wire logic                       FIXED_CODE_SELECT,
  input  wire logic                       VID_LINK_CLOCK,
  input  wire logic                       VID_LINK_DATA_IN,
  output logic                            VID_LINK_DATA_OUT,
  output logic                            VID_LINK_DATA_OE,
  output logic                            DRIVE_EN,
  output logic                            OUTPUT_POWER_GOOD,
  output logic [svr_pkg::CODE_W-1:0]      CORE_PLANE_0_REF,
  output logic [svr_pkg::CODE_W-1:0]      CORE_PLANE_1_REF,
  output logic [svr_pkg::CODE_W-1:0]      NORTHBRIDGE_PLANE_REF,
  output logic [2:0]                      PLANE_ON,
  output logic                            CONTINUOUS_CONDUCTION,
  output logic                            POWER_SAVING_HINT_N,
  input  wire logic [4:0]                 AVS_ADDRESS,
  input  wire logic                       AVS_READ,
  input  wire logic                       AVS_WRITE,
  input  wire logic [31:0]                AVS_WRITEDATA,
  input  wire logic [3:0]                 AVS_BYTEENABLE,
  output logic [31:0]                     AVS_READDATA,
  output logic                            AVS_WAITREQUEST
);
  import svr_pkg::*;

  typedef struct packed {
    logic [5:0]             s1;
    logic [5:0]             s2;
    logic [1:0]             s3;
    svr_state_t             st;
    logic [CODE_W-1:0]      hold;
    logic                   hold_ok;
    logic                   fixed;
    logic [2:0][CODE_W-1:0] tgt;
    logic                   psi_n;
    logic                   output_power_good;
    svr_link_t              lk;
    logic [3:0]             bits;
    logic [7:0]             shf;
    logic [2:0]             sel;
    logic                   cmd_ok;
    logic                   oe;
    logic [DIV_W-1:0]       div;
    logic [1:0]             ctrl;
    logic                   ack;
    logic [31:0]            rdata;
  } svr_main_t;

  svr_main_t m_q;
  svr_main_t m_d;

  logic                   en_ok;
  logic                   processor_power_ok;
  logic                   scl;
  logic                   sda;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_c;
  logic                   stop_c;
  logic                   listen;
  logic                   tick;
  logic                   at_tgt;
  logic [DIV_W-1:0]       period;
  logic [2:0]             dn;
  logic [2:0][CODE_W-1:0] refs;
  logic [1:0]             pin_idx;
  logic                   avs_req;

  // ****************************************************
  // pin conditioning and link edges
  // ****************************************************
  // sync lanes: 0 enable, 1 por, 2 power ok, 3 fixed, 4 clock, 5 data
  assign en_ok    = m_q.s2[0] && !m_q.s2[1];
  assign processor_power_ok    = m_q.s2[2];
  assign scl      = m_q.s2[4];
  assign sda      = m_q.s2[5];
  assign pin_idx  = {scl, sda};
  // start and stop seen with clock high
  assign scl_rise = scl && !m_q.s3[0];
  assign scl_fall = !scl && m_q.s3[0];
  assign start_c  = scl && m_q.s3[0] && m_q.s3[1] && !sda;
  assign stop_c   = scl && m_q.s3[0] && !m_q.s3[1] && sda;
  // link watched only once power ok is up
  assign listen   = (m_q.st == ST_SVI) && m_q.ctrl[CTRL_LINK];
  // slow soft-start tick, faster slew tick
  assign period   = (m_q.st == ST_SOFT) ? DIV_W'(SOFT_STEP_CYC - 1)
                                        : DIV_W'(SLEW_STEP_CYC - 1);
  assign tick     = (m_q.st != ST_OFF) && (m_q.div == period);
  assign at_tgt   = (refs[0] == ((m_q.tgt[0] >= CODE_OFF) ? CODE_OFF
                                                          : m_q.tgt[0]))
                 && (refs[1] == ((m_q.tgt[1] >= CODE_OFF) ? CODE_OFF
                                                          : m_q.tgt[1]))
                 && (refs[2] == ((m_q.tgt[2] >= CODE_OFF) ? CODE_OFF
                                                          : m_q.tgt[2]));
  assign avs_req  = AVS_READ || AVS_WRITE;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    m_d    = m_q;
    m_d.s1 = {VID_LINK_DATA_IN, VID_LINK_CLOCK, FIXED_CODE_SELECT,
              PROCESSOR_POWER_OK, BIAS_POR, ENABLE};
    m_d.s2 = m_q.s1;
    m_d.s3 = {sda, scl};
    m_d.div = tick ? '0 : m_q.div + 1'b1;

    case (m_q.st)
      ST_OFF: begin
        m_d.div = '0;
        if (en_ok) begin
          m_d.fixed   = m_q.s2[3];
          if (m_q.s2[3]) begin
            m_d.hold = FIX_CODE[pin_idx];
          // fresh start code latched on enable
          end else begin
            m_d.hold = BOOT_CODE[pin_idx];
          end
          m_d.hold_ok = 1'b1;
          m_d.tgt     = {3{m_d.hold}};
          m_d.psi_n   = 1'b1;
          m_d.st      = ST_SOFT;
        end
      end
      ST_SOFT: begin
        // power good once every plane sits on target
        if (at_tgt) begin
          m_d.output_power_good = 1'b1;
          m_d.st    = ST_BOOT;
        end
      end
      ST_BOOT: begin
        // targets kept until a new command arrives
        if (processor_power_ok && !m_q.fixed) begin
          m_d.st = ST_SVI;
        end
      end
      ST_SVI: begin
        // back to the held code, pins not read
        if (!processor_power_ok) begin
          m_d.tgt = {3{m_q.hold}};
          m_d.st  = ST_BOOT;
        end
      end
      default: begin
        m_d.st = ST_OFF;
      end
    endcase

    // link slave, never drives the clock
    if (!listen) begin
      m_d.lk     = LK_IDLE;
      m_d.oe     = 1'b0;
      m_d.cmd_ok = 1'b0;
    end else if (start_c) begin
      m_d.lk     = LK_ADDR;
      m_d.bits   = '0;
      m_d.oe     = 1'b0;
      m_d.cmd_ok = 1'b0;
    end else if (stop_c) begin
      if (m_q.cmd_ok && processor_power_ok) begin
        if (m_q.sel[1]) begin
          m_d.tgt[0] = m_q.shf[6:0];
        end
        if (m_q.sel[2]) begin
          m_d.tgt[1] = m_q.shf[6:0];
        end
        if (m_q.sel[0]) begin
          m_d.tgt[2] = m_q.shf[6:0];
        end
        m_d.psi_n = m_q.shf[7];
      end
      m_d.lk     = LK_IDLE;
      m_d.oe     = 1'b0;
      m_d.cmd_ok = 1'b0;
    end else begin
      case (m_q.lk)
        LK_ADDR, LK_DATA: begin
          if (scl_rise) begin
            m_d.shf  = {m_q.shf[6:0], sda};
            m_d.bits = m_q.bits + 4'h1;
          end else if (scl_fall && m_q.bits == 4'(BYTE_BITS)) begin
            if (m_q.lk == LK_DATA) begin
              m_d.oe = 1'b1;
              m_d.lk = LK_DACK;
            // address 110, write, some plane picked
            end else if (m_q.shf[7:5] == ADDR_HI && !m_q.shf[0]
                         && m_q.shf[3:1] != 3'h0) begin
              m_d.sel = m_q.shf[3:1];
              m_d.oe  = 1'b1;
              m_d.lk  = LK_AACK;
            end else begin
              m_d.lk = LK_WAIT;
            end
          end
        end
        LK_AACK: begin
          if (scl_fall) begin
            m_d.oe   = 1'b0;
            m_d.bits = '0;
            m_d.lk   = LK_DATA;
          end
        end
        LK_DACK: begin
          if (scl_fall) begin
            m_d.oe     = 1'b0;
            m_d.cmd_ok = 1'b1;
            m_d.lk     = LK_WAIT;
          end
        end
        default: begin
          m_d.lk = m_q.lk;
        end
      endcase
    end

    // loss of enable or bias drops state, power good, held code and targets
    if (!en_ok) begin
      m_d.st      = ST_OFF;
      m_d.output_power_good   = 1'b0;
      m_d.hold_ok = 1'b0;
      m_d.hold    = CODE_OFF;
      m_d.tgt     = {3{CODE_OFF}};
    end

    // register slave, one wait state
    m_d.ack = avs_req && !m_q.ack;
    if (AVS_READ && !m_q.ack) begin
      if (AVS_ADDRESS == OFS_CTRL) begin
        m_d.rdata = {30'h0, m_q.ctrl};
      end else if (AVS_ADDRESS == OFS_STATUS) begin
        m_d.rdata = {17'h0, m_q.hold, CONTINUOUS_CONDUCTION, m_q.hold_ok,
                     m_q.fixed, processor_power_ok, m_q.output_power_good, 1'b0, m_q.st};
      end else if (AVS_ADDRESS == OFS_TARGET) begin
        m_d.rdata = {7'h0, m_q.psi_n, 1'b0, m_q.tgt[2], 1'b0, m_q.tgt[1],
                     1'b0, m_q.tgt[0]};
      end else if (AVS_ADDRESS == OFS_REF) begin
        m_d.rdata = {9'h0, refs[2], 1'b0, refs[1], 1'b0, refs[0]};
      end else begin
        m_d.rdata = 32'h0;
      end
    end
    if (AVS_WRITE && m_q.ack && AVS_ADDRESS == OFS_CTRL
        && AVS_BYTEENABLE[0]) begin
      m_d.ctrl = AVS_WRITEDATA[1:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      m_q         <= '0;
      m_q.st      <= ST_OFF;
      m_q.lk      <= LK_IDLE;
      m_q.hold    <= CODE_OFF;
      m_q.tgt     <= {3{CODE_OFF}};
      m_q.psi_n   <= 1'b1;
      m_q.ctrl    <= CTRL_RST;
    end else begin
      m_q <= m_d;
    end
  end

  // ****************************************************
  // plane steppers
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_plane
      svr_ramp u_ramp (
        .clk      (SYS_CLK),
        .rst      (RESET),
        .zero     (m_q.st == ST_OFF),
        .tick     (tick),
        .target   (m_q.tgt[g]),
        .ref_code (refs[g]),
        .down     (dn[g])
      );
    end
  endgenerate

  // ****************************************************
  // outputs
  // ****************************************************
  assign VID_LINK_DATA_OUT     = 1'b0;
  assign VID_LINK_DATA_OE      = m_q.oe;
  assign DRIVE_EN              = m_q.st != ST_OFF;
  // power good cleared only by enable or bias loss, or by RESET
  assign OUTPUT_POWER_GOOD     = m_q.output_power_good;
  // code order: plane 0, plane 1, northbridge
  assign CORE_PLANE_0_REF      = refs[0];
  assign CORE_PLANE_1_REF      = refs[1];
  assign NORTHBRIDGE_PLANE_REF = refs[2];
  assign PLANE_ON              = {refs[2] < CODE_OFF, refs[1] < CODE_OFF,
                                  refs[0] < CODE_OFF};
  assign CONTINUOUS_CONDUCTION = m_q.ctrl[CTRL_CCM]
                              || ((m_q.st == ST_SVI || m_q.st == ST_BOOT)
                                  && dn != 3'h0);
  assign POWER_SAVING_HINT_N   = m_q.psi_n;
  assign AVS_READDATA          = m_q.rdata;
  assign AVS_WAITREQUEST       = avs_req && !m_q.ack;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  chk_off_output_power_good_low: assert property (
    !en_ok |=> !OUTPUT_POWER_GOOD && !DRIVE_EN && !m_q.hold_ok)
    else $error("enable loss did not drop outputs");
  chk_hold_latch: assert property (
    m_q.st == ST_OFF && en_ok && !m_q.s2[3]
    |=> m_q.hold == BOOT_CODE[$past(pin_idx)] && m_q.st == ST_SOFT)
    else $error("start code not latched from pins");
  chk_fixed_latch: assert property (
    m_q.st == ST_OFF && en_ok && m_q.s2[3]
    |=> m_q.hold == FIX_CODE[$past(pin_idx)])
    else $error("fixed code not latched from straps");
  chk_output_power_good_rise: assert property (
    $rose(OUTPUT_POWER_GOOD) |-> $past(m_q.st) == ST_SOFT && $past(at_tgt))
    else $error("power good rose before soft-start end");
  chk_output_power_good_hold: assert property (
    OUTPUT_POWER_GOOD && en_ok |=> OUTPUT_POWER_GOOD)
    else $error("power good fell while enabled");
  chk_processor_power_ok_return: assert property (
    m_q.st == ST_SVI && !processor_power_ok && en_ok
    |=> m_q.tgt == {3{$past(m_q.hold)}} && m_q.st == ST_BOOT)
    else $error("power ok loss did not restore held code");
  chk_ccm_down: assert property (
    m_q.st == ST_SVI
    && ((refs[0] < m_q.tgt[0] && refs[0] < CODE_OFF)
     || (refs[1] < m_q.tgt[1] && refs[1] < CODE_OFF)
     || (refs[2] < m_q.tgt[2] && refs[2] < CODE_OFF))
    |-> CONTINUOUS_CONDUCTION)
    else $error("downward step without continuous conduction");
  chk_ack_place: assert property (
    VID_LINK_DATA_OE |-> m_q.lk == LK_AACK || m_q.lk == LK_DACK)
    else $error("data wire driven outside acknowledge");
  chk_apply_stop: assert property (
    m_q.tgt != $past(m_q.tgt) && $past(m_q.st) == ST_SVI && $past(processor_power_ok)
    && $past(en_ok) |-> $past(stop_c) && $past(m_q.cmd_ok))
    else $error("target changed without a stop");
  chk_slew_period: assert property (
    tick && m_q.st == ST_SVI |=> !tick [*8])
    else $error("slew ticks too close");

  cov_soft_done: cover property ($rose(OUTPUT_POWER_GOOD));
  cov_cmd_apply: cover property (stop_c && m_q.cmd_ok && listen);
  cov_processor_power_ok_drop: cover property (m_q.st == ST_SVI && !processor_power_ok);

endmodule // svr_ctrl

// >>> svr_proc_model.sv
/*
  behavioural processor on the serial voltage link: link master that
  sends send-byte frames and records the two acknowledge bits.
  assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/10ps
module svr_proc_model (
  output logic       link_clk,
  output logic       data_oe,
  input  wire logic  data_in,
  output logic [1:0] acks
);
  localparam real HALF = 62.5;

  initial begin
    link_clk = 1'b1;
    data_oe  = 1'b0;
    acks     = 2'b00;
  end

  // ****************************************************
  // bit level
  // ****************************************************
  // two-wire bit timing
  task automatic put_bit(input logic b);
    data_oe = ~b;
    #(HALF / 2);
    link_clk = 1'b1;
    #HALF;
    link_clk = 1'b0;
    #(HALF / 2);
  endtask

  task automatic get_ack(input int k);
    data_oe = 1'b0;
    #(HALF / 2);
    link_clk = 1'b1;
    #(HALF / 2);
    acks[k] = ~data_in;
    #(HALF / 2);
    link_clk = 1'b0;
    #(HALF / 2);
  endtask

  // ****************************************************
  // frame level
  // ****************************************************
  // master send-byte frame
  task automatic send(input logic [7:0] adr, input logic [7:0] dat);
    acks    = 2'b00;
    data_oe = 1'b1;
    #HALF;
    link_clk = 1'b0;
    #(HALF / 2);
    for (int i = 7; i >= 0; i--) put_bit(adr[i]);
    get_ack(1);
    for (int i = 7; i >= 0; i--) put_bit(dat[i]);
    get_ack(0);
    data_oe = 1'b1;
    #(HALF / 2);
    link_clk = 1'b1;
    #HALF;
    data_oe = 1'b0;
    #HALF;
  endtask
endmodule // svr_proc_model

// >>> testbench.sv
/*
  self-checking bench of svr_ctrl: start-up, power good, link commands.
  assumes svr_proc_model as link master; the data wire has a pull-up.
*/
`timescale 1ns/10ps
module testbench;
  import svr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b0;
  logic        por = 1'b0;
  logic        pok = 1'b0;
  logic        fix = 1'b0;
  logic        lclk, poe, doe, dout, ldat, drv, pg, continuous_conduction, hn;
  logic [6:0]  c0, c1, nb, t0, t1, t2;
  logic [2:0]  pon;
  logic [4:0]  avs_a = 5'h00;
  logic        avs_rd = 1'b0;
  logic        avs_wr = 1'b0;
  logic [31:0] avs_wd = 32'h0, avs_q, rd;
  logic        avs_wait, h, rh;
  logic        watch = 1'b0;
  logic        pg_drop = 1'b0;
  logic        ccm_seen = 1'b0;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          gap;

  assign ldat = ~(doe | poe);

  svr_proc_model u_proc (.link_clk(lclk), .data_oe(poe), .data_in(ldat),
    .acks());

  svr_ctrl u_svr_ctrl (.SYS_CLK(clk), .RESET(rst), .ENABLE(en),
    .BIAS_POR(por), .PROCESSOR_POWER_OK(pok), .FIXED_CODE_SELECT(fix),
    .VID_LINK_CLOCK(lclk), .VID_LINK_DATA_IN(ldat),
    .VID_LINK_DATA_OUT(dout), .VID_LINK_DATA_OE(doe), .DRIVE_EN(drv),
    .OUTPUT_POWER_GOOD(pg), .CORE_PLANE_0_REF(c0), .CORE_PLANE_1_REF(c1),
    .NORTHBRIDGE_PLANE_REF(nb), .PLANE_ON(pon),
    .CONTINUOUS_CONDUCTION(continuous_conduction), .POWER_SAVING_HINT_N(hn),
    .AVS_ADDRESS(avs_a), .AVS_READ(avs_rd), .AVS_WRITE(avs_wr),
    .AVS_WRITEDATA(avs_wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_q),
    .AVS_WAITREQUEST(avs_wait));

  always #5 clk = ~clk;

  // ****************************************************
  // monitors and timeout
  // ****************************************************
  always @(posedge clk) begin
    cyc++;
    if (watch && pg !== 1'b1) pg_drop <= 1'b1;
    if (watch && continuous_conduction === 1'b1) ccm_seen <= 1'b1;
    if (cyc == 90000) begin
      n_fail++;
      close_out();
    end
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_a  <= a;
    avs_wd <= d;
    avs_rd <= ~w;
    avs_wr <= w;
    @(posedge clk);
    while (avs_wait !== 1'b0) @(posedge clk);
    rd = avs_q;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask

  function automatic logic [31:0] refs();
    return {11'h0, c0, c1, nb};
  endfunction

  function automatic logic [31:0] exp_refs();
    return {11'h0, t0, t1, t2};
  endfunction

  task automatic step_gap(output int g);
    logic [6:0] v;
    g = 0;
    @(negedge clk);
    v = c1;
    while (c1 === v) @(negedge clk);
    v = c1;
    while (c1 === v) begin
      @(negedge clk);
      g++;
    end
  endtask

  task automatic cmd(input logic [7:0] a, input logic [7:0] d,
                     input logic ok);
    u_proc.send(a, d);
    chk("ack", 32'({ok, ok}), 32'(u_proc.acks));
    if (ok && a[2]) t0 = d[6:0];
    if (ok && a[3]) t1 = d[6:0];
    if (ok && a[1]) t2 = d[6:0];
    if (ok) h = d[7];
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_TARGET, 32'h0);
    chk("target", {7'h0, h, 1'b0, t2, 1'b0, t1, 1'b0, t0}, rd);
  endtask

  task automatic settle();
    int k = 0;
    @(negedge clk);
    while (refs() !== exp_refs() && k < 66 * SLEW_STEP_CYC) begin
      @(negedge clk);
      k++;
    end
    chk("refs", exp_refs(), refs());
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    void'($urandom(32'h59a224cf));
    t0 = 7'h3C;
    t1 = 7'h3C;
    t2 = 7'h3C;
    h  = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    chk("drive off", 32'h0, 32'(drv));
    bus(1'b1, 5'h14, $urandom);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    en <= 1'b1;
    step_gap(gap);
    chk("soft gap", 32'(SOFT_STEP_CYC), 32'(gap));
    chk("output_power_good early", 32'h0, 32'(pg));
    while (pg !== 1'b1) @(negedge clk);
    chk("refs at output_power_good", exp_refs(), refs());
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status boot", 32'h3C4A, rd);
    pok <= 1'b1;
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status serial", 32'h3C5B, rd);
    bus(1'b1, OFS_CTRL, 32'h2);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl write", 32'h2, rd);
    chk("ccm forced", 32'h1, 32'(continuous_conduction));
    cmd(8'hCE, 8'h30, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h1);
    cmd(8'hAE, 8'h30, 1'b0);
    rh = 1'($urandom);
    watch = 1'b1;
    cmd(8'hCE, {rh, 7'h40}, 1'b1);
    chk("hint", 32'(rh), 32'(hn));
    step_gap(gap);
    chk("slew gap", 32'(SLEW_STEP_CYC), 32'(gap));
    settle();
    chk("ccm down", 32'h1, 32'(ccm_seen));
    // core plane 0 off only; the northbridge plane stays on
    cmd(8'hC4, 8'hFC, 1'b1);
    settle();
    chk("plane on", 32'h6, 32'(pon));
    @(posedge clk);
    pok <= 1'b0;
    t0 = 7'h3C;
    t1 = 7'h3C;
    t2 = 7'h3C;
    settle();
    @(posedge clk);
    pok <= 1'b1;
    repeat (50) @(posedge clk);
    bus(1'b0, OFS_TARGET, 32'h0);
    chk("target kept", 32'h3C3C3C, rd & 32'h7F7F7F);
    chk("output_power_good kept", 32'h0, 32'(pg_drop));
    watch = 1'b0;
    en <= 1'b0;
    repeat (8) @(posedge clk);
    chk("output_power_good en low", 32'h0, 32'(pg));
    chk("drive en low", 32'h0, 32'(drv));
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("held cleared", 32'h7C00, rd & 32'h7F40);
    en <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("held relatch", 32'h3C40, rd & 32'h7F40);
    chk("drive en on", 32'h1, 32'(drv));
    por <= 1'b1;
    repeat (8) @(posedge clk);
    chk("por output_power_good", 32'h0, 32'(pg));
    chk("por planes", 32'h0, 32'(pon));
    chk("por drive", 32'h0, 32'(drv));
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("por held", 32'h7C00, rd & 32'h7F40);
    por <= 1'b0;
    close_out();
  end
endmodule // testbench
